// ### src/rgf_pkg.sv
// Package for the reset generation and failsafe block.
// Assumes a single 20 MHz system clock domain.
package rgf_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    // External reset pin debounce time
    localparam int unsigned DEB_TIME_NS = 1000;
    localparam int unsigned DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Minimum reset time for dynamic causes
    localparam int unsigned MIN_RST_TIME_NS = 2000;
    localparam int unsigned MIN_RST_CYCLES = (MIN_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

    // Static causes
    typedef struct packed {
        logic core_por;
        logic core_bod;
        logic io_bod;
    } rgf_static_s;

    // Dynamic causes that request reset
    typedef struct packed {
        logic flash_uncorr;
        logic flash_erased_read;
        logic ram_parity;
        logic ram_uninit_read;
        logic cpu_reg_parity;
        logic wdog_timeout;
        logic trim_ecc_uncorr;
        logic clk_monitor_fail;
    } rgf_dyn_s;

    // Events that raise an interrupt only
    typedef struct packed {
        logic flash_corr;
        logic flash_write;
        logic undef_opcode;
        logic misaligned;
        logic exec_protect;
        logic stack_overflow;
        logic invalid_reg_access;
        logic wdog_window;
    } rgf_irq_s;

    typedef enum logic [1:0] {
        RGF_ST_STATIC = 2'b00,
        RGF_ST_HOLD = 2'b01,
        RGF_ST_RUN = 2'b11
    } rgf_state_e;
endpackage

// ### src/rgf_reset_gen.sv
// Reset generator with failsafe event mapping and pad direction control.
// Assumes supply monitor flags and the reset pin are asynchronous; events from
// memory, CPU and watchdog come from logic on ref_clk_i.
//
// Overview of operation
// - Debounced low external pin resets chip
// - Static cause holds reset until gone
// - Dynamic cause holds reset minimum time
// - Dynamic cause still active restarts period
// - Power-on and core brown-out are static
// - Memory, parity, watchdog, trim errors dynamic
// - Core or IO undervoltage causes reset
// - Over-voltage never causes reset
// - Reset forces all pads to input
// - Pads stay input until software reprograms
// - IO supply watched once core in range
// - Supply loss at power-down forces reset
// - Power-on reset follows threshold with hysteresis
// - Listed soft faults raise interrupt only
// - Listed hard faults assert reset
`timescale 1ns/1ps
module rgf_reset_gen
    import rgf_pkg::*;
#(
    parameter int unsigned PAD_W = 8,
    parameter int unsigned DEB_CNT = DEB_CYCLES,
    parameter int unsigned MIN_CNT = MIN_RST_CYCLES
) (
    // Clock and power-on reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // External reset pin, active low, asynchronous
    input wire logic ext_rst_b_i,
    // Supply monitors, asynchronous
    input wire logic core_above_por_i,
    input wire logic core_above_min_i,
    input wire logic io_in_range_i,
    input wire logic io_over_voltage_i,
    // Failsafe events, same clock
    input wire rgf_dyn_s dyn_i,
    input wire rgf_irq_s irq_src_i,
    // Pad direction from software
    input wire logic pad_dir_we_i,
    input wire logic [PAD_W-1:0] pad_dir_out_i,
    // Outputs
    output logic sys_rst_b_o,
    output logic failsafe_irq_o,
    output logic [PAD_W-1:0] pad_oe_b_o
);
    // Synchronisers for asynchronous inputs
    logic [3:0] sync1;
    logic [3:0] sync2;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {ext_rst_b_i, core_above_por_i, core_above_min_i, io_in_range_i};
            sync2 <= sync1;
        end
    end
    logic pin_s, por_ok_s, core_min_s, io_ok_s;
    assign {pin_s, por_ok_s, core_min_s, io_ok_s} = sync2;

    // Power-on reset with hysteresis
    logic por_active, next_por_active;
    always_comb begin
        next_por_active = por_active;
        if (por_active && por_ok_s) begin
            next_por_active = 1'b0;
        end else if (!por_active && !core_min_s) begin
            next_por_active = 1'b1;
        end
    end

    // Pin debounce
    logic [CNT_W-1:0] deb_cnt, next_deb_cnt;
    logic pin_rst, next_pin_rst;
    always_comb begin
        next_deb_cnt = CNT_ZERO;
        next_pin_rst = 1'b0;
        if (!pin_s) begin
            if (deb_cnt >= CNT_W'(DEB_CNT)) begin
                next_deb_cnt = deb_cnt;
                next_pin_rst = 1'b1;
            end else begin
                next_deb_cnt = deb_cnt + 16'h0001;
            end
        end
    end

    // Static causes; over-voltage deliberately ignored
    rgf_static_s stat;
    logic io_bod_ok;
    always_comb begin
        stat.core_por = por_active;
        stat.core_bod = !core_min_s;
        io_bod_ok = io_ok_s || !core_min_s;
        stat.io_bod = !io_bod_ok;
    end
    logic static_cause;
    assign static_cause = (|stat) || pin_rst;

    logic dyn_cause;
    assign dyn_cause = |dyn_i;

    // Reset state machine
    function automatic logic hold_done(input logic [CNT_W-1:0] cnt);
        return cnt >= CNT_W'(MIN_CNT - 1);
    endfunction

    rgf_state_e state, next_state;
    logic [CNT_W-1:0] hold_cnt, next_hold_cnt;
    always_comb begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        case (state)
            RGF_ST_STATIC: begin
                if (!static_cause) begin
                    next_state = dyn_cause ? RGF_ST_HOLD : RGF_ST_RUN;
                    next_hold_cnt = CNT_ZERO;
                end
            end
            RGF_ST_HOLD: begin
                if (static_cause) begin
                    next_state = RGF_ST_STATIC;
                end else if (hold_done(hold_cnt)) begin
                    next_hold_cnt = CNT_ZERO;
                    next_state = dyn_cause ? RGF_ST_HOLD : RGF_ST_RUN;
                end else begin
                    next_hold_cnt = hold_cnt + 16'h0001;
                end
            end
            RGF_ST_RUN: begin
                if (static_cause) begin
                    next_state = RGF_ST_STATIC;
                end else if (dyn_cause) begin
                    next_state = RGF_ST_HOLD;
                    next_hold_cnt = CNT_ZERO;
                end
            end
            default: begin
                next_state = RGF_ST_STATIC;
                next_hold_cnt = CNT_ZERO;
            end
        endcase
    end

    // Outputs
    logic next_rst_b, next_irq;
    logic [PAD_W-1:0] next_pad_oe_b;
    always_comb begin
        next_rst_b = (next_state == RGF_ST_RUN);
        next_irq = |irq_src_i;
        next_pad_oe_b = pad_oe_b_o;
        if (next_state != RGF_ST_RUN) begin
            next_pad_oe_b = {PAD_W{1'b1}};
        end else if (pad_dir_we_i && sys_rst_b_o) begin
            next_pad_oe_b = ~pad_dir_out_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            por_active <= 1'b1;
            deb_cnt <= CNT_ZERO;
            pin_rst <= 1'b0;
            state <= RGF_ST_STATIC;
            hold_cnt <= CNT_ZERO;
            sys_rst_b_o <= 1'b0;
            failsafe_irq_o <= 1'b0;
            pad_oe_b_o <= {PAD_W{1'b1}};
        end else begin
            por_active <= next_por_active;
            deb_cnt <= next_deb_cnt;
            pin_rst <= next_pin_rst;
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            sys_rst_b_o <= next_rst_b;
            failsafe_irq_o <= next_irq;
            pad_oe_b_o <= next_pad_oe_b;
        end
    end

    // Assertions
    int unsigned low_run;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_run <= 0;
        end else begin
            low_run <= sys_rst_b_o ? 0 : low_run + 1;
        end
    end

    pin_debounce_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!pin_s && deb_cnt >= CNT_W'(DEB_CNT)) |=> pin_rst)
        else $error("debounced pin low did not raise reset");
    static_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        static_cause |=> !sys_rst_b_o)
        else $error("static cause did not hold reset");
    dyn_min_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ($rose(sys_rst_b_o) && $past(state) == RGF_ST_HOLD) |-> low_run >= MIN_CNT)
        else $error("reset released without hold");
    dyn_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (state == RGF_ST_RUN && dyn_cause && !static_cause) |=> state == RGF_ST_HOLD ##1 !sys_rst_b_o)
        else $error("dynamic cause did not start hold");
    dyn_retrig_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (state == RGF_ST_HOLD && hold_cnt >= CNT_W'(MIN_CNT - 1) && dyn_cause && !static_cause)
        |=> state == RGF_ST_HOLD && hold_cnt == CNT_ZERO)
        else $error("active dynamic cause did not retrigger");
    io_watch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (core_min_s && !io_ok_s) |=> state == RGF_ST_STATIC)
        else $error("io supply loss missed");
    pad_input_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !sys_rst_b_o |-> pad_oe_b_o == {PAD_W{1'b1}})
        else $error("pad driven during reset");
    por_hyst_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!por_active && core_min_s) |=> !por_active)
        else $error("power-on reset reasserted above minimum");
    irq_map_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (|irq_src_i && !dyn_cause && !static_cause && state == RGF_ST_RUN) |=> failsafe_irq_o && sys_rst_b_o)
        else $error("interrupt event caused reset or no interrupt");

    // Reset sources
    pin_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        pin_s |=> !pin_rst)
        else $error("pin reset set while pin high");
    pin_static_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        pin_rst |=> state == RGF_ST_STATIC)
        else $error("pin reset not held as static");
    deb_sat_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        deb_cnt <= CNT_W'(DEB_CNT))
        else $error("debounce counter overran");
    static_release_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (state == RGF_ST_STATIC && !static_cause && !dyn_cause) |=> sys_rst_b_o)
        else $error("reset not released after static cause");
    por_static_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        por_active |=> state == RGF_ST_STATIC && !sys_rst_b_o)
        else $error("power-on reset not static");
    core_bod_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !core_min_s |=> state == RGF_ST_STATIC && !sys_rst_b_o)
        else $error("core brown-out missed");
    dyn_src_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        dyn_cause |=> !sys_rst_b_o)
        else $error("hard fault did not reset");
    dyn_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (state == RGF_ST_HOLD && !static_cause && !hold_done(hold_cnt))
        |=> state == RGF_ST_HOLD && hold_cnt == $past(hold_cnt) + 16'h0001)
        else $error("minimum reset time cut short");
    dyn_release_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (state == RGF_ST_HOLD && hold_done(hold_cnt) && !dyn_cause && !static_cause) |=> sys_rst_b_o)
        else $error("reset not released after minimum time");
    hold_range_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        hold_cnt <= CNT_W'(MIN_CNT - 1))
        else $error("hold counter overran");
    ov_ignore_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (io_over_voltage_i && state == RGF_ST_RUN && !static_cause && !dyn_cause) |=> sys_rst_b_o)
        else $error("over-voltage caused reset");
    por_release_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (por_active && por_ok_s) |=> !por_active)
        else $error("power-on reset not released above threshold");
    sync_release_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        sys_rst_b_o == (state == RGF_ST_RUN))
        else $error("system reset not aligned to state");

    // Pads
    powerdown_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!io_ok_s || !core_min_s) |=> !sys_rst_b_o && pad_oe_b_o == {PAD_W{1'b1}})
        else $error("supply loss did not reset pads");
    pad_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (state == RGF_ST_RUN && next_state == RGF_ST_RUN && !pad_dir_we_i) |=> $stable(pad_oe_b_o))
        else $error("pad direction changed without write");
    pad_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (pad_dir_we_i && sys_rst_b_o && next_state == RGF_ST_RUN) |=> pad_oe_b_o == ~$past(pad_dir_out_i))
        else $error("pad direction write lost");

    // Interrupt
    irq_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !(|irq_src_i) |=> !failsafe_irq_o)
        else $error("interrupt without event");

    pin_reset_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $rose(pin_rst));
    retrig_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state == RGF_ST_HOLD && hold_cnt == CNT_W'(MIN_CNT - 1) && dyn_cause);
    release_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $rose(sys_rst_b_o));
    static_exit_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state == RGF_ST_STATIC ##1 state == RGF_ST_RUN);
    irq_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $rose(failsafe_irq_o));
endmodule

// ### tb/rgf_supply_model.sv
// Model of the outside reset driver and the supply monitors.
// Assumes the bench commands supply states on ref_clk_i.
`timescale 1ns/1ps
module rgf_supply_model #(
    parameter int unsigned SETTLE = 8
) (
    // Clock and bench commands
    input wire logic ref_clk_i,
    input wire logic por_ok_i,
    input wire logic core_ok_i,
    input wire logic io_ok_i,
    input wire logic ov_i,
    input wire logic pin_low_i,
    // Toward the device
    output logic core_above_por_o,
    output logic core_above_min_o,
    output logic io_in_range_o,
    output logic io_over_voltage_o,
    output logic ext_rst_b_o
);
    int stable = 0;
    always @(posedge ref_clk_i) begin
        core_above_por_o <= por_ok_i;
        core_above_min_o <= core_ok_i;
        io_in_range_o <= io_ok_i;
        io_over_voltage_o <= ov_i;
        stable <= (por_ok_i && core_ok_i && io_ok_i) ? stable + 1 : 0;
        // Pin let go only once supplies have settled
        ext_rst_b_o <= !pin_low_i && stable >= SETTLE;
    end
endmodule

// ### tb/tb.sv
// Self-checking bench for the reset generator.
// Assumes the supply model drives the pin and supply flags.
`timescale 1ns/1ps
module tb;
    import rgf_pkg::*;
    localparam int unsigned MINC = 4;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic por_ok = 1'b1;
    logic core_ok = 1'b1;
    logic io_ok = 1'b1;
    logic ov = 1'b0;
    logic pin_low = 1'b0;
    logic por_f, min_f, io_f, ov_f, pin_b, sys_b, fs_irq;
    rgf_dyn_s dyn = '0;
    rgf_irq_s irq = '0;
    logic pad_we = 1'b0;
    logic [7:0] pad_dir = 8'h00;
    logic [7:0] oe_b;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int a;
    always #25 ref_clk_i = ~ref_clk_i;
    rgf_supply_model i_sup (.ref_clk_i(ref_clk_i), .por_ok_i(por_ok), .core_ok_i(core_ok), .io_ok_i(io_ok),
        .ov_i(ov), .pin_low_i(pin_low), .core_above_por_o(por_f), .core_above_min_o(min_f),
        .io_in_range_o(io_f), .io_over_voltage_o(ov_f), .ext_rst_b_o(pin_b));
    rgf_reset_gen #(.PAD_W(8), .DEB_CNT(3), .MIN_CNT(MINC)) i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .ext_rst_b_i(pin_b), .core_above_por_i(por_f), .core_above_min_i(min_f), .io_in_range_i(io_f),
        .io_over_voltage_i(ov_f), .dyn_i(dyn), .irq_src_i(irq), .pad_dir_we_i(pad_we),
        .pad_dir_out_i(pad_dir), .sys_rst_b_o(sys_b), .failsafe_irq_o(fs_irq), .pad_oe_b_o(oe_b));
    task automatic close_out;
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk1(string what, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Counts cycles with system reset low
    task automatic run(int n, output int lows);
        lows = 0;
        repeat (n) begin
            @(negedge ref_clk_i);
            if (sys_b === 1'b0) lows++;
        end
    endtask
    task automatic wr_pads;
        @(posedge ref_clk_i);
        pad_we <= 1'b1;
        pad_dir <= 8'h0F;
        @(posedge ref_clk_i);
        pad_we <= 1'b0;
        run(2, a);
        chk8("pad_write", 8'hF0, oe_b);
    endtask
    task automatic t_dyn;
        for (int i = 0; i < 8; i++) begin
            wr_pads();
            @(posedge ref_clk_i);
            dyn <= rgf_dyn_s'(8'h01 << i);
            @(posedge ref_clk_i);
            dyn <= '0;
            run(MINC + 12, a);
            chk1("dyn_min_time", 1'b1, a >= MINC);
            chk1("dyn_release", 1'b1, sys_b);
            chk8("pads_after_dyn", 8'hFF, oe_b);
        end
    endtask
    task automatic t_retrig;
        @(posedge ref_clk_i);
        dyn <= rgf_dyn_s'(8'h04);
        run(14, a);
        chk1("retrig_held", 1'b1, a >= 11);
        @(posedge ref_clk_i);
        dyn <= '0;
        run(MINC + 12, a);
        chk1("retrig_release", 1'b1, sys_b);
    endtask
    task automatic t_static;
        for (int k = 0; k < 3; k++) begin
            wr_pads();
            @(posedge ref_clk_i);
            por_ok <= (k != 0);
            core_ok <= (k == 2);
            io_ok <= (k != 2);
            run(20, a);
            chk1("static_held", 1'b1, a >= 15 && sys_b === 1'b0);
            @(posedge ref_clk_i);
            {por_ok, core_ok, io_ok} <= 3'b111;
            run(40, a);
            chk1("static_release", 1'b1, sys_b);
            chk8("pads_after_loss", 8'hFF, oe_b);
        end
    endtask
    task automatic t_quiet(int sel);
        @(posedge ref_clk_i);
        if (sel == 0) ov <= 1'b1;
        else pin_low <= 1'b1;
        repeat (sel == 0 ? 20 : 3) @(posedge ref_clk_i);
        ov <= 1'b0;
        pin_low <= 1'b0;
        run(20, a);
        chk1("no_reset", 1'b1, a == 0);
    endtask
    task automatic t_pin;
        @(posedge ref_clk_i);
        pin_low <= 1'b1;
        run(14, a);
        chk1("pin_reset", 1'b1, a >= 2 && sys_b === 1'b0);
        @(posedge ref_clk_i);
        pin_low <= 1'b0;
        run(40, a);
        chk1("pin_release", 1'b1, sys_b);
    endtask
    task automatic t_irq;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk_i);
            irq <= rgf_irq_s'(8'h01 << i);
            @(posedge ref_clk_i);
            irq <= '0;
            @(negedge ref_clk_i);
            chk1("irq_set", 1'b1, fs_irq);
            @(negedge ref_clk_i);
            chk1("irq_clear", 1'b0, fs_irq);
            chk1("irq_no_reset", 1'b1, sys_b);
        end
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        chk8("pads_in_reset", 8'hFF, oe_b);
        run(40, a);
        chk1("power_up", 1'b1, sys_b);
        t_dyn();
        t_retrig();
        t_static();
        t_quiet(0);
        t_quiet(1);
        t_pin();
        t_irq();
        close_out();
    end
endmodule
